// ### hw/rcl_pkg.sv
// Purpose: Shared constants and types for the reset configuration word loader
// Assumes: 24-bit program addresses, 24-bit flash words, 16-bit table data
// Notes: Configuration locations are byte wide; the upper table byte reads as ones
`default_nettype none

package rcl_pkg;

  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam int LOC_W = 8;
  localparam int LOC_NUM = 5;

  // Flash configuration word one for each flash size; word two sits two below it
  localparam logic [ADDR_W-1:0] CW1_ADDR_16K = 24'h00_2BFE;
  localparam logic [ADDR_W-1:0] CW1_ADDR_32K = 24'h00_57FE;
  localparam logic [ADDR_W-1:0] CW1_ADDR_48K = 24'h00_83FE;
  localparam logic [ADDR_W-1:0] CW1_ADDR_64K = 24'h00_ABFE;
  localparam logic [ADDR_W-1:0] CW_STRIDE = 24'h00_0002;

  // Configuration space and the five volatile locations in it
  localparam logic [ADDR_W-1:0] CFG_SPACE_LO = 24'h80_0000;
  localparam logic [ADDR_W-1:0] CFG_BASE = 24'hF8_0000;
  localparam logic [ADDR_W-1:0] CFG_LOC_STEP = 24'h00_0002;
  localparam logic [ADDR_W-1:0] CFG_SPAN = 24'h00_000A;

  // Unprogrammed value of every configuration bit
  localparam logic [LOC_W-1:0] LOC_ERASED = 8'hFF;
  localparam logic [DATA_W-1:0] RDATA_NONE = 16'h0000;

  // Field masks and shifts that scatter the two packed words
  localparam logic [DATA_W-1:0] MASK_WDT = 16'h00FF;
  localparam logic [DATA_W-1:0] MASK_DBG = 16'h0F00;
  localparam logic [DATA_W-1:0] MASK_PROT = 16'h7000;
  localparam logic [DATA_W-1:0] MASK_CLK = 16'h00FF;
  localparam logic [DATA_W-1:0] MASK_OSC = 16'h8700;
  localparam int SHIFT_LO = 0;
  localparam int SHIFT_HI = 8;

  typedef enum logic [1:0] {
    FS_16K = 2'b00,
    FS_32K = 2'b01,
    FS_48K = 2'b10,
    FS_64K = 2'b11
  } rcl_flash_size_t;

  typedef enum logic [2:0] {
    ST_REQ1 = 3'b000,
    ST_WAIT1 = 3'b001,
    ST_REQ2 = 3'b010,
    ST_WAIT2 = 3'b011,
    ST_DONE = 3'b100
  } rcl_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rcl_tbl_req_t;

  typedef struct packed {
    logic [LOC_W-1:0] osc;
    logic [LOC_W-1:0] clk;
    logic [LOC_W-1:0] prot;
    logic [LOC_W-1:0] dbg;
    logic [LOC_W-1:0] wdt;
  } rcl_cfg_set_t;

endpackage : rcl_pkg

`default_nettype wire

// ### hw/rcl_field_pick.sv
// Purpose: Pick masked fields out of a packed word into one configuration byte
// Assumes: Bits outside the mask are unimplemented and read as one
// Notes: Only the low sixteen bits ever arrive here
`default_nettype none

module rcl_field_pick #(
  parameter logic [15:0] MASK = 16'h00FF,
  parameter int SHIFT = 0
) (
  input wire logic [15:0] word,
  output logic [7:0] field
);

  logic [15:0] filled;
  logic [15:0] shifted;

  assign filled = (word & MASK) | ~MASK;
  assign shifted = filled >> SHIFT;
  assign field = shifted[7:0];

endmodule : rcl_field_pick

`default_nettype wire

// ### hw/rcl_loader.sv
// Purpose: Reload volatile configuration locations from flash on every reset
// Assumes: Flash answers each read pulse with one valid pulse; table port is synchronous
// Notes: Core reset stays asserted until both words have been unpacked
//
// Behaviour
// - Programmed bit reads zero, unprogrammed one
// - Configuration locations start at fixed base
// - Config space reached only by table access
// - Volatile storage refilled before settings apply
// - Source is top two flash words
// - Unpack two words into five locations
// - Reload on every kind of reset
// - Word addresses scale with flash size
// - Upper byte of each word ignored
`default_nettype none

module rcl_loader (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_req,
  input wire rcl_pkg::rcl_flash_size_t flash_size,
  output logic flash_rd_req,
  output logic [rcl_pkg::ADDR_W-1:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [rcl_pkg::WORD_W-1:0] flash_rd_data,
  input wire rcl_pkg::rcl_tbl_req_t tbl_req,
  output logic tbl_ack,
  output logic [rcl_pkg::DATA_W-1:0] tbl_rdata,
  output rcl_pkg::rcl_cfg_set_t cfg,
  output logic core_rst
);
  import rcl_pkg::*;

  rcl_state_t state_reg;
  rcl_state_t state_next;
  rcl_cfg_set_t cfg_reg;
  rcl_cfg_set_t cfg_next;
  logic req_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic core_rst_reg;
  logic [ADDR_W-1:0] cw1_addr;
  logic [ADDR_W-1:0] cw2_addr;
  logic [DATA_W-1:0] word_lo;
  logic [LOC_W-1:0] pick_wdt;
  logic [LOC_W-1:0] pick_dbg;
  logic [LOC_W-1:0] pick_prot;
  logic [LOC_W-1:0] pick_clk;
  logic [LOC_W-1:0] pick_osc;
  logic in_req;
  logic got_w1;
  logic got_w2;
  logic tbl_any;
  logic in_cfg_space;
  logic [ADDR_W-1:0] tbl_off;
  logic cfg_hit;
  logic [2:0] loc_idx;
  logic [LOC_W-1:0] loc_rd;
  logic tbl_wr_hit;

  // Word one address follows the flash size, word two sits one word below
  assign cw1_addr = (flash_size == FS_16K) ? CW1_ADDR_16K :
                    (flash_size == FS_32K) ? CW1_ADDR_32K :
                    (flash_size == FS_48K) ? CW1_ADDR_48K : CW1_ADDR_64K;
  assign cw2_addr = cw1_addr - CW_STRIDE;

  // Upper byte never reaches the unpackers, so an image padded with ones is harmless
  assign word_lo = flash_rd_data[DATA_W-1:0];

  rcl_field_pick #(.MASK(MASK_WDT), .SHIFT(SHIFT_LO)) u_pick_wdt (
    .word(word_lo),
    .field(pick_wdt)
  );
  rcl_field_pick #(.MASK(MASK_DBG), .SHIFT(SHIFT_HI)) u_pick_dbg (
    .word(word_lo),
    .field(pick_dbg)
  );
  rcl_field_pick #(.MASK(MASK_PROT), .SHIFT(SHIFT_HI)) u_pick_prot (
    .word(word_lo),
    .field(pick_prot)
  );
  rcl_field_pick #(.MASK(MASK_CLK), .SHIFT(SHIFT_LO)) u_pick_clk (
    .word(word_lo),
    .field(pick_clk)
  );
  rcl_field_pick #(.MASK(MASK_OSC), .SHIFT(SHIFT_HI)) u_pick_osc (
    .word(word_lo),
    .field(pick_osc)
  );

  assign in_req = (state_reg == ST_REQ1) || (state_reg == ST_REQ2);
  assign got_w1 = (state_reg == ST_WAIT1) && flash_rd_valid;
  assign got_w2 = (state_reg == ST_WAIT2) && flash_rd_valid;
  assign addr_next = (state_reg == ST_REQ1) ? cw1_addr :
                     (state_reg == ST_REQ2) ? cw2_addr : addr_reg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_REQ1: state_next = ST_WAIT1;
      ST_WAIT1: state_next = flash_rd_valid ? ST_REQ2 : ST_WAIT1;
      ST_REQ2: state_next = ST_WAIT2;
      ST_WAIT2: state_next = flash_rd_valid ? ST_DONE : ST_WAIT2;
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_REQ1;
    endcase
  end

  // Table access only; nothing here is visible to fetch or data space
  assign tbl_any = tbl_req.rd || tbl_req.wr;
  assign in_cfg_space = tbl_req.addr >= CFG_SPACE_LO;
  assign tbl_off = tbl_req.addr - CFG_BASE;
  assign cfg_hit = in_cfg_space && (tbl_req.addr >= CFG_BASE) && (tbl_off < CFG_SPAN)
                   && !tbl_req.addr[0];
  assign loc_idx = tbl_off[3:1];
  assign loc_rd = (loc_idx == 3'd0) ? cfg_reg.wdt :
                  (loc_idx == 3'd1) ? cfg_reg.dbg :
                  (loc_idx == 3'd2) ? cfg_reg.prot :
                  (loc_idx == 3'd3) ? cfg_reg.clk : cfg_reg.osc;
  // Config hits take effect only in ST_DONE; before that writes are dropped and reads return zero, though still acked
  assign tbl_wr_hit = tbl_req.wr && cfg_hit && (state_reg == ST_DONE);
  assign rdata_next = (tbl_req.rd && cfg_hit && state_reg == ST_DONE) ?
                      {LOC_ERASED, loc_rd} : RDATA_NONE;

  always_comb
  begin
    cfg_next = cfg_reg;
    if (got_w1)
    begin
      cfg_next.wdt = pick_wdt;
      cfg_next.dbg = pick_dbg;
      cfg_next.prot = pick_prot;
    end
    if (got_w2)
    begin
      cfg_next.clk = pick_clk;
      cfg_next.osc = pick_osc;
    end
    if (tbl_wr_hit)
    begin
      unique case (loc_idx)
        3'd0: cfg_next.wdt = tbl_req.wdata[LOC_W-1:0];
        3'd1: cfg_next.dbg = tbl_req.wdata[LOC_W-1:0];
        3'd2: cfg_next.prot = tbl_req.wdata[LOC_W-1:0];
        3'd3: cfg_next.clk = tbl_req.wdata[LOC_W-1:0];
        default: cfg_next.osc = tbl_req.wdata[LOC_W-1:0];
      endcase
    end
  end

  // Every reset source restarts the load from erased locations
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_REQ1;
      cfg_reg <= {LOC_NUM{LOC_ERASED}};
      core_rst_reg <= 1'b1;
    end
    else if (reset_req)
    begin
      state_reg <= ST_REQ1;
      cfg_reg <= {LOC_NUM{LOC_ERASED}};
      core_rst_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      core_rst_reg <= (state_next != ST_DONE);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_reg <= 1'b0;
      addr_reg <= '0;
      ack_reg <= 1'b0;
      rdata_reg <= RDATA_NONE;
    end
    else
    begin
      req_reg <= in_req && !reset_req;
      addr_reg <= addr_next;
      ack_reg <= tbl_any;
      rdata_reg <= rdata_next;
    end
  end

  assign flash_rd_req = req_reg;
  assign flash_rd_addr = addr_reg;
  assign tbl_ack = ack_reg;
  assign tbl_rdata = rdata_reg;
  assign cfg = cfg_reg;
  assign core_rst = core_rst_reg;

  a_core_held_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg != ST_DONE) |-> core_rst_reg)
    else $error("core released before configuration load");
  a_word1_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == ST_REQ1 && !reset_req) |=> flash_rd_req && flash_rd_addr == $past(cw1_addr))
    else $error("word one read address wrong");
  a_word2_below: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == ST_REQ2 && !reset_req) |=> flash_rd_addr == $past(cw1_addr) - CW_STRIDE)
    else $error("word two not two below word one");
  a_unpack_word1: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (got_w1 && !reset_req) |=> cfg_reg.wdt == $past(flash_rd_data[LOC_W-1:0]))
    else $error("watchdog location not loaded from word one");
  // Oscillator byte must come from the low sixteen bits only, masked bits forced to one
  a_upper_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (got_w2 && !reset_req) |=> cfg_reg.clk == $past(flash_rd_data[LOC_W-1:0])
    && cfg_reg.osc == ($past(flash_rd_data[DATA_W-1:SHIFT_HI]) | ~MASK_OSC[DATA_W-1:SHIFT_HI]))
    else $error("upper byte leaked into configuration");
  a_reload_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reset_req |=> core_rst_reg && state_reg == ST_REQ1 && cfg_reg == {LOC_NUM{LOC_ERASED}})
    else $error("reset request did not restart load");
  a_volatile_refill: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(core_rst_reg) |-> $past(state_reg) == ST_WAIT2 && $past(flash_rd_valid))
    else $error("settings applied without second word");
  a_read_pads_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tbl_req.rd && cfg_hit && state_reg == ST_DONE)
    |=> tbl_ack && tbl_rdata[DATA_W-1:LOC_W] == LOC_ERASED)
    else $error("configuration read upper byte not ones");
  a_base_location: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tbl_req.rd && tbl_req.addr == CFG_BASE && state_reg == ST_DONE && !got_w1)
    |=> tbl_rdata[LOC_W-1:0] == $past(cfg_reg.wdt))
    else $error("base address does not read first location");
  a_outside_space: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tbl_req.rd && tbl_req.addr < CFG_SPACE_LO) |=> tbl_rdata == RDATA_NONE)
    else $error("table read below configuration space returned data");

  c_load_done: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(core_rst_reg));
  c_warm_reload: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == ST_DONE) ##1 reset_req);
  c_table_write: cover property (@(posedge sys_clk) disable iff (sys_rst) tbl_wr_hit);

endmodule : rcl_loader

`default_nettype wire

// ### sim/rcl_flash_model.sv
// Purpose: Program flash model that holds the two configuration words
// Assumes: One read outstanding at a time; the bench sets the answer delay
// Notes: When idle the data line flips to the inverse of its last value, so the last word returns every second cycle
`default_nettype none

module rcl_flash_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic rd_req,
  input wire logic [23:0] rd_addr,
  input wire logic [3:0] delay,
  input wire logic [23:0] top_addr,
  input wire logic [15:0] w1,
  input wire logic [15:0] w2,
  output logic rd_valid,
  output logic [23:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_reg;
  logic [15:0] low;
  // Code is never placed at the word slots, so other addresses read as zero
  assign low = (rd_addr == top_addr) ? w1 :
    (rd_addr == top_addr - 24'h00_0002) ? w2 : 16'h0000;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 5'h00;
      rd_valid <= 1'b0;
      rd_data <= 24'h00_0000;
    end
    else
    begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req)
        cnt_reg <= {1'b0, delay} + 5'h01;
      else if (cnt_reg == 5'h01)
      begin
        cnt_reg <= 5'h00;
        rd_valid <= 1'b1;
        rd_data <= {8'hFF, low};
      end
      else if (cnt_reg != 5'h00)
        cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule : rcl_flash_model

`default_nettype wire

// ### sim/rcl_loader_tb.sv
// Purpose: Self-checking bench for the reset configuration word loader
// Assumes: Inputs change on the falling edge; flash model answers after a set delay
// Notes: Expected bytes come from the field split, not from the design
`default_nettype none

module rcl_loader_tb;
  import rcl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_req = 1'b0;
  rcl_flash_size_t flash_size = FS_64K;
  logic flash_rd_req, flash_rd_valid, tbl_ack, core_rst;
  logic [23:0] flash_rd_addr, flash_rd_data;
  logic [23:0] top_addr = 24'h00_ABFE;
  logic [15:0] tbl_rdata;
  logic [15:0] w1 = 16'h5A3C;
  logic [15:0] w2 = 16'hC6E1;
  logic [3:0] delay = 4'h6;
  rcl_tbl_req_t tbl_req = '0;
  rcl_cfg_set_t cfg;
  int failures = 0;
  int num_checks = 0;
  logic [23:0] req_log[$];

  always #25 sys_clk = ~sys_clk;
  // Logged mid-cycle so the request pulse is read where it has settled
  always @(negedge sys_clk) if (flash_rd_req === 1'b1) req_log.push_back(flash_rd_addr);

  rcl_loader i_rcl_loader (.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_req(reset_req),
    .flash_size(flash_size), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data), .tbl_req(tbl_req),
    .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata), .cfg(cfg), .core_rst(core_rst));
  rcl_flash_model i_rcl_flash_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .rd_req(flash_rd_req), .rd_addr(flash_rd_addr), .delay(delay), .top_addr(top_addr),
    .w1(w1), .w2(w2), .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));

  task chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  function automatic logic [39:0] exp_cfg(input logic [15:0] a, input logic [15:0] b);
    return {b[15], 4'hF, b[10:8], b[7:0], 1'b1, a[14:12], 4'hF, 4'hF, a[11:8], a[7:0]};
  endfunction : exp_cfg

  task do_reset(input rcl_flash_size_t fs, input logic [23:0] top);
    @(negedge sys_clk);
    flash_size = fs;
    top_addr = top;
    sys_rst = 1'b1;
    req_log.delete();
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask : do_reset

  task wait_load;
    int n;
    n = 0;
    while (core_rst !== 1'b0 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(core_rst === 1'b0, "load did not finish");
  endtask : wait_load

  // Request held one cycle, released once the ack edge has passed
  task tbl(input logic rd, input logic [23:0] a, input logic [15:0] wd, input logic [15:0] ex);
    @(negedge sys_clk);
    tbl_req = '{rd: rd, wr: ~rd, addr: a, wdata: wd};
    @(negedge sys_clk);
    tbl_req = '0;
    chk(tbl_ack === 1'b1 && (!rd || tbl_rdata === ex), "table access");
  endtask : tbl

  task check_locs(input logic [15:0] a, input logic [15:0] b);
    logic [39:0] e;
    e = exp_cfg(a, b);
    chk(cfg === e, "cfg contents");
    for (int i = 0; i < 5; i++)
      tbl(1'b1, 24'hF8_0000 + 24'(2 * i), 16'h0000, {8'hFF, e[8 * i +: 8]});
  endtask : check_locs

  task t_boot;
    do_reset(FS_64K, 24'h00_ABFE);
    repeat (3) @(negedge sys_clk);
    chk(core_rst === 1'b1 && cfg === 40'hFF_FFFF_FFFF, "early release");
    tbl(1'b1, 24'hF8_0000, 16'h0000, 16'h0000);
    tbl(1'b0, 24'hF8_0000, 16'h0000, 16'h0000);
    wait_load();
    chk(req_log.size() == 2 && req_log[0] === 24'h00_ABFE, "word one address");
    chk(req_log[1] === 24'h00_ABFC, "word two address");
    check_locs(w1, w2);
    $display("boot test done");
  endtask : t_boot

  task t_table;
    logic [39:0] e;
    e = exp_cfg(w1, w2);
    tbl(1'b0, 24'hF8_0000, 16'h1234, 16'h0000);
    tbl(1'b1, 24'hF8_0000, 16'h0000, 16'hFF34);
    tbl(1'b1, 24'hF8_000A, 16'h0000, 16'h0000);
    tbl(1'b1, 24'hF8_0001, 16'h0000, 16'h0000);
    tbl(1'b1, 24'h00_ABFE, 16'h0000, 16'h0000);
    tbl(1'b0, 24'hF8_000A, 16'h0000, 16'h0000);
    chk(cfg.wdt === 8'h34 && cfg.osc === e[39:32], "write effect");
    $display("table test done");
  endtask : t_table

  task t_soft;
    @(negedge sys_clk);
    reset_req = 1'b1;
    @(negedge sys_clk);
    reset_req = 1'b0;
    chk(core_rst === 1'b1 && cfg === 40'hFF_FFFF_FFFF, "soft reset clear");
    wait_load();
    check_locs(w1, w2);
    $display("soft reset test done");
  endtask : t_soft

  task t_sizes;
    logic [23:0] tops[4];
    tops = '{24'h00_2BFE, 24'h00_57FE, 24'h00_83FE, 24'h00_ABFE};
    delay = 4'h0;
    w1 = 16'hFFFF;
    w2 = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(rcl_flash_size_t'(i), tops[i]);
      wait_load();
      chk(req_log[0] === tops[i] && req_log[1] === tops[i] - 24'h00_0002, "size addr");
      chk(cfg === exp_cfg(w1, w2), "erased and programmed bits");
    end
    $display("flash size test done");
  endtask : t_sizes

  initial
  begin
    t_boot();
    t_table();
    t_soft();
    t_sizes();
    print_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #200_000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : rcl_loader_tb

`default_nettype wire
